// ==== verilog/dot_ctrl.sv ====
// on-die termination control: read turn-off, dynamic strength, frozen-dll async mode
// Overview of operation
// - termination comes on when the device stops driving the data bus
// - dynamic mode is on when either write-strength bit of MR2 is set
// - nominal code from MR1 bits 9,6,2; write code from MR2 bits 10,9
// - without writes use nominal; on/off WL-2 clocks after ODT registered
// - in dynamic mode a write selects write strength WL-2 clocks later
// - nominal returns 6+ODTLoff clocks after write for BL8, 4+ODTLoff for BC4
// - strength changes land half a clock after the latency point
// - async mode in precharge power-down when MR0 bit 12 is clear and MR1 bit 0 (DLL disable) is clear
// - async mode does not delay ODT by the additive latency
// - async mode follows the sampled ODT level directly, not clocked latencies
// - near frozen power-down entry/exit either sync or async timing is allowed
// - the transition lead interval is WL-1 clocks around the CKE change
// - sync latency is CWL + AL - 2, so additive latency applies to ODT
// - with all termination codes zero the ODT pin is ignored
//
// Decided for this implementation: the address-and-strobe port and the address map.
`timescale 1ns/10ps
`default_nettype none
module dot_ctrl #(
  parameter int DEPTH = 32
) (
  // clocking
  input  wire logic              core_clk,
  input  wire logic              reset_n,
  input  wire logic              ce,
  // memory pins, asynchronous to core_clk
  input  wire logic              ck,
  input  wire logic              cke,
  input  wire logic              odt,
  input  wire dot_pkg::dot_cmd_s cmd,
  // device-internal state, same clock domain
  input  wire logic              dq_drive,
  input  wire logic              banks_idle,
  // register port
  input  wire logic [7:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [31:0]       reg_rdata,
  // termination switch
  output dot_pkg::dot_rtt_s      rtt
);
  localparam int PW = 3 + $bits(dot_pkg::dot_cmd_s);

  typedef enum logic [1:0] {
    DOT_RUN   = 2'b00,
    DOT_PD    = 2'b01,
    DOT_ASYNC = 2'b10
  } dot_mode_e;

  logic [PW-1:0]     pins_s;
  logic              ck_s;
  logic              ck_d_r;
  logic              cke_s;
  logic              odt_s;
  dot_pkg::dot_cmd_s cmd_s;
  logic              ck_rise;
  logic              ck_fall;

  dot_sync #(.W(PW)) u_sync (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .ce       (ce),
    .d        ({ck, cke, odt, cmd}),
    .q        (pins_s)
  );

  assign ck_s    = pins_s[PW-1];
  assign cke_s   = pins_s[PW-2];
  assign odt_s   = pins_s[PW-3];
  assign cmd_s   = pins_s[PW-4:0];
  assign ck_rise = ck_s & ~ck_d_r;
  assign ck_fall = ~ck_s & ck_d_r;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ck_d_r <= 1'b0;
    end else if (ce) begin
      ck_d_r <= ck_s;
    end
  end

  // command decode at each registered link edge
  logic cmd_sel;
  logic mrs_cmd;
  logic wr_cmd;
  assign cmd_sel = ck_rise & ~cmd_s.cs_n;
  assign mrs_cmd = cmd_sel & ~cmd_s.ras_n & ~cmd_s.cas_n & ~cmd_s.we_n;
  assign wr_cmd  = cmd_sel & cmd_s.ras_n & ~cmd_s.cas_n & ~cmd_s.we_n;

  // mode register mirrors: mode-set commands win over the register port
  logic [15:0] mr0_r;
  logic [15:0] mr1_r;
  logic [15:0] mr2_r;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      mr0_r <= dot_pkg::MR0_RST;
      mr1_r <= dot_pkg::MR1_RST;
      mr2_r <= dot_pkg::MR2_RST;
    end else if (ce) begin
      if (mrs_cmd) begin
        if (cmd_s.ba == 3'h0) begin
          mr0_r <= cmd_s.addr;
        end else if (cmd_s.ba == 3'h1) begin
          mr1_r <= cmd_s.addr;
        end else if (cmd_s.ba == 3'h2) begin
          mr2_r <= cmd_s.addr;
        end
      end else if (reg_wr) begin
        if (reg_addr == dot_pkg::MR0_OFS) begin
          mr0_r <= reg_wdata[15:0];
        end else if (reg_addr == dot_pkg::MR1_OFS) begin
          mr1_r <= reg_wdata[15:0];
        end else if (reg_addr == dot_pkg::MR2_OFS) begin
          mr2_r <= reg_wdata[15:0];
        end
      end
    end
  end

  // field views
  logic [2:0] nom_code;
  logic [1:0] wr_code;
  logic       odt_en;
  logic       dyn_en;
  logic       dll_off;
  logic [4:0] cwl;
  logic [4:0] cl;
  logic [4:0] al;
  logic [4:0] odtl;
  logic [4:0] wl;

  assign nom_code = {mr1_r[dot_pkg::MR1_NOM2_BIT], mr1_r[dot_pkg::MR1_NOM1_BIT],
                     mr1_r[dot_pkg::MR1_NOM0_BIT]};
  assign wr_code  = mr2_r[dot_pkg::MR2_WR_LO +: 2];
  assign dll_off  = mr1_r[dot_pkg::MR1_DLLD_BIT];
  // pin ignored when all codes zero
  assign odt_en   = (|nom_code) | (|wr_code);
  // dynamic enable; dll-off relies on the controller having cleared it
  assign dyn_en   = |wr_code;

  assign cwl = {2'b00, mr2_r[dot_pkg::MR2_CWL_LO +: 3]} + dot_pkg::CWL_BASE;
  assign cl  = {2'b00, mr0_r[dot_pkg::MR0_CL_LO +: 3]} + dot_pkg::CL_BASE;

  always_comb begin
    case (mr1_r[dot_pkg::MR1_AL_LO +: 2])
      2'h1:    al = cl - 5'h01;
      2'h2:    al = cl - 5'h02;
      default: al = 5'h00;
    endcase
  end

  // additive latency folded into the odt latency
  assign wl   = cwl + al;
  assign odtl = wl - dot_pkg::ODTL_SUB;

  // burst length of this write: fixed by mode or chosen on the fly
  logic wr_bl8;
  always_comb begin
    case (mr0_r[dot_pkg::MR0_BL_LO +: 2])
      dot_pkg::BL_FIX8: wr_bl8 = 1'b1;
      dot_pkg::BL_OTF:  wr_bl8 = cmd_s.addr[dot_pkg::ADDR_BC_BIT];
      default:          wr_bl8 = 1'b0;
    endcase
  end

  // power-down tracking and mode selection
  dot_mode_e  mode_r;
  logic       cke_reg_r;
  logic [4:0] trans_cnt_r;
  logic       async_req;

  // frozen dll only in precharge power-down with bit 12 clear
  assign async_req = ~cke_s & banks_idle & ~dll_off & ~mr0_r[dot_pkg::MR0_PPD_BIT];

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_r    <= DOT_RUN;
      cke_reg_r <= 1'b1;
    end else if (ce && ck_rise) begin
      cke_reg_r <= cke_s;
      case (mode_r)
        DOT_RUN: begin
          if (!cke_s) begin
            mode_r <= async_req ? DOT_ASYNC : DOT_PD;
          end
        end
        DOT_PD, DOT_ASYNC: begin
          if (cke_s) begin
            mode_r <= DOT_RUN;
          end
        end
        default: mode_r <= DOT_RUN;
      endcase
    end
  end

  // lead interval of WL-1 clocks around each CKE change
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      trans_cnt_r <= 5'h00;
    end else if (ce && ck_rise) begin
      if (cke_s != cke_reg_r) begin
        trans_cnt_r <= wl - dot_pkg::TANPD_SUB;
      end else if (trans_cnt_r != 5'h00) begin
        trans_cnt_r <= trans_cnt_r - 5'h01;
      end
    end
  end

  logic async_mode;
  assign async_mode = (mode_r == DOT_ASYNC);

  // latency lines stepped on each registered edge
  logic [DEPTH-1:0] odt_line;
  logic [DEPTH-1:0] w8_line;
  logic [DEPTH-1:0] w4_line;

  dot_pipe #(.DEPTH(DEPTH)) u_odt_line (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .ce       (ce),
    .step     (ck_rise),
    .flush    (1'b0),
    .din      (odt_s),
    .line     (odt_line)
  );

  dot_pipe #(.DEPTH(DEPTH)) u_w8_line (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .ce       (ce),
    .step     (ck_rise),
    .flush    (~dyn_en),
    .din      (wr_cmd & wr_bl8),
    .line     (w8_line)
  );

  dot_pipe #(.DEPTH(DEPTH)) u_w4_line (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .ce       (ce),
    .step     (ck_rise),
    .flush    (~dyn_en),
    .din      (wr_cmd & ~wr_bl8),
    .line     (w4_line)
  );

  // decisions at the latency edge, applied on the following falling edge
  logic on_pend_r;
  logic wr_set_r;
  logic wr_clr_r;
  logic term_r;
  logic use_wr_r;
  logic rtt_on_r;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      on_pend_r <= 1'b0;
      wr_set_r  <= 1'b0;
      wr_clr_r  <= 1'b0;
    end else if (ce && ck_rise) begin
      on_pend_r <= odt_line[odtl - 5'h01];
      wr_set_r  <= w8_line[odtl - 5'h01] | w4_line[odtl - 5'h01];
      // back to nominal per burst length
      wr_clr_r  <= w8_line[odtl + dot_pkg::CWN8_EXTRA - 5'h01]
                 | w4_line[odtl + dot_pkg::CWN4_EXTRA - 5'h01];
    end
  end

  // transition windows take whichever path is active, both legal
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      term_r <= 1'b0;
    end else if (ce) begin
      if (async_mode) begin
        term_r <= odt_s;
      end else if (ck_fall) begin
        // half a clock after the latency point
        term_r <= on_pend_r;
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      use_wr_r <= 1'b0;
    end else if (ce) begin
      if (!dyn_en || async_mode) begin
        use_wr_r <= 1'b0;
      end else if (ck_fall) begin
        // strength change on falling edge; a new write beats the return
        if (wr_set_r) begin
          use_wr_r <= 1'b1;
        end else if (wr_clr_r) begin
          use_wr_r <= 1'b0;
        end
      end
    end
  end

  // termination on once the bus is released
  // dq_drive holds it off even if ODT stays high into read data
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rtt_on_r <= 1'b0;
    end else if (ce) begin
      rtt_on_r <= term_r & odt_en & ~dq_drive;
    end
  end

  assign rtt.on       = rtt_on_r;
  assign rtt.use_wr   = use_wr_r;
  assign rtt.nom_code = nom_code;
  assign rtt.wr_code  = wr_code;

  // register read, data one cycle after the strobe
  logic [31:0] rd_nxt;
  always_comb begin
    rd_nxt = 32'h0000_0000;
    if (reg_addr == dot_pkg::MR0_OFS) begin
      rd_nxt = {16'h0000, mr0_r};
    end else if (reg_addr == dot_pkg::MR1_OFS) begin
      rd_nxt = {16'h0000, mr1_r};
    end else if (reg_addr == dot_pkg::MR2_OFS) begin
      rd_nxt = {16'h0000, mr2_r};
    end else if (reg_addr == dot_pkg::STAT_OFS) begin
      rd_nxt = {20'h00000, odtl, (trans_cnt_r != 5'h00), mode_r,
                dyn_en, odt_en, use_wr_r, rtt_on_r};
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 32'h0000_0000;
    end else if (ce) begin
      reg_rdata <= reg_rd ? rd_nxt : 32'h0000_0000;
    end
  end

  // checks
  sequence bus_released_s;
    ce && !dq_drive && term_r && odt_en;
  endsequence

  odt_ignore_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    ce && !odt_en |=> !rtt_on_r) else $error("termination on while all codes zero");

  drive_off_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    ce && dq_drive |=> !rtt_on_r) else $error("termination on while driving");

  release_on_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    bus_released_s |=> rtt_on_r) else $error("termination late after bus release");

  dyn_off_nom_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    ce && !dyn_en |=> !use_wr_r) else $error("write strength without dynamic mode");

  wr_fall_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    $rose(use_wr_r) |-> $past(ck_fall)) else $error("strength change off the falling edge");

  sync_fall_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    $changed(term_r) && !$past(async_mode) |-> $past(ck_fall))
    else $error("sync termination change off the falling edge");

  sequence async_hold_s;
    (ce && async_mode && odt_s)[*2];
  endsequence

  async_follow_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    async_hold_s |-> term_r) else $error("async termination not following odt");

  wr_switch_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    ce && wr_cmd && dyn_en && !async_mode && odtl > 5'h02 ##1 (ce && dyn_en)[*8]
    |-> ##[1:400] use_wr_r) else $error("write strength never selected");

  wr_return_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    $fell(use_wr_r) && dyn_en && !async_mode |-> $past(wr_clr_r))
    else $error("nominal return without its latency point");

  lat_sum_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    $changed(mr1_r[dot_pkg::MR1_AL_LO +: 2]) && mr1_r[dot_pkg::MR1_AL_LO +: 2] == 2'h1
    |-> odtl == cwl + cl - 5'h03) else $error("odt latency ignores additive latency");
endmodule : dot_ctrl
`default_nettype wire

// ==== verilog/dot_pkg.sv ====
// shared constants and carrier types for the on-die termination controller
package dot_pkg;
  // register byte offsets
  localparam logic [7:0] MR0_OFS  = 8'h00;
  localparam logic [7:0] MR1_OFS  = 8'h04;
  localparam logic [7:0] MR2_OFS  = 8'h08;
  localparam logic [7:0] STAT_OFS = 8'h0C;
  // reset values of mode register mirrors
  localparam logic [15:0] MR0_RST = 16'h0000;
  localparam logic [15:0] MR1_RST = 16'h0000;
  localparam logic [15:0] MR2_RST = 16'h0000;
  // field positions
  localparam int MR0_PPD_BIT  = 12;
  localparam int MR0_BL_LO    = 0;
  localparam int MR0_CL_LO    = 4;
  localparam int MR1_DLLD_BIT = 0;
  localparam int MR1_AL_LO    = 3;
  localparam int MR1_NOM0_BIT = 2;
  localparam int MR1_NOM1_BIT = 6;
  localparam int MR1_NOM2_BIT = 9;
  localparam int MR2_CWL_LO   = 3;
  localparam int MR2_WR_LO    = 9;
  localparam int ADDR_BC_BIT  = 12;
  // latency arithmetic, in link clock cycles
  localparam logic [4:0] CWL_BASE   = 5'h05;
  localparam logic [4:0] CL_BASE    = 5'h04;
  localparam logic [4:0] ODTL_SUB   = 5'h02;
  localparam logic [4:0] TANPD_SUB  = 5'h01;
  localparam logic [4:0] CWN8_EXTRA = 5'h06;
  localparam logic [4:0] CWN4_EXTRA = 5'h04;
  localparam logic [4:0] ODTH4      = 5'h04;
  localparam logic [4:0] ODTH8      = 5'h06;
  // burst length field codes
  localparam logic [1:0] BL_FIX8 = 2'h0;
  localparam logic [1:0] BL_OTF  = 2'h1;
  // command pins of one registered edge
  typedef struct packed {
    logic       cs_n;
    logic       ras_n;
    logic       cas_n;
    logic       we_n;
    logic [2:0] ba;
    logic [15:0] addr;
  } dot_cmd_s;
  // termination state shown to the analog switch
  typedef struct packed {
    logic       on;
    logic       use_wr;
    logic [2:0] nom_code;
    logic [1:0] wr_code;
  } dot_rtt_s;
endpackage : dot_pkg

// ==== verilog/dot_sync.sv ====
// two-flop synchroniser for a bundle of pin inputs
`timescale 1ns/10ps
`default_nettype none
module dot_sync #(
  parameter int W = 1
) (
  // clocking
  input  wire logic         core_clk,
  input  wire logic         reset_n,
  input  wire logic         ce,
  // data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_r <= '0;
      q      <= '0;
    end else if (ce) begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule : dot_sync
`default_nettype wire

// ==== verilog/dot_pipe.sv ====
// shift line stepped once per link clock rise, every stage visible
`timescale 1ns/10ps
`default_nettype none
module dot_pipe #(
  parameter int DEPTH = 32
) (
  // clocking
  input  wire logic             core_clk,
  input  wire logic             reset_n,
  input  wire logic             ce,
  // stepping
  input  wire logic             step,
  input  wire logic             flush,
  input  wire logic             din,
  output logic      [DEPTH-1:0] line
);
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      line <= '0;
    end else if (ce) begin
      if (flush) begin
        line <= '0;
      end else if (step) begin
        line <= {line[DEPTH-2:0], din};
      end
    end
  end
endmodule : dot_pipe
`default_nettype wire

// ==== bench/dot_mc_model.sv ====
// memory-controller side model: link clock, cke, odt and command pins
`timescale 1ns/10ps
`default_nettype none
module dot_mc_model (
  // link pins
  output logic              ck,
  output logic              cke,
  output logic              odt,
  output dot_pkg::dot_cmd_s cmd
);
  localparam dot_pkg::dot_cmd_s DESEL = '{1'h1, 1'h1, 1'h1, 1'h1, 3'h0, 16'h0000};
  // free-running: the link clock stays stable through power-down too
  initial begin
    ck = 1'h0;
    cke = 1'h1;
    odt = 1'h0;
    cmd = DESEL;
    #13;
    forever #160 ck = ~ck;
  end
  task automatic rises(input int n);
    repeat (n) @(posedge ck);
  endtask : rises
  // pins move at the falling edge, clear of the sampling rise
  task automatic set_pin(input logic o, input logic e);
    @(negedge ck);
    odt = o;
    cke = e;
  endtask : set_pin
  // one mode-set command on the pins, then deselect
  task automatic mrs(input logic [2:0] b, input logic [15:0] a);
    @(negedge ck);
    cmd = '{1'h0, 1'h0, 1'h0, 1'h0, b, a};
    @(negedge ck);
    cmd = DESEL;
  endtask : mrs
  task automatic burst(input int hold, input bit wr, input bit bl8);
    int n;
    n = (wr && bl8) ? 6 : 4;
    if (hold > n) n = hold;
    @(negedge ck);
    odt = 1'h1;
    if (wr) cmd = '{1'h0, 1'h1, 1'h0, 1'h0, 3'h0, {3'h0, bl8, 12'h000}};
    @(negedge ck);
    cmd = DESEL;
    repeat (n - 1) @(negedge ck);
    odt = 1'h0;
  endtask : burst
endmodule : dot_mc_model
`default_nettype wire

// ==== bench/dot_ctrl_bench.sv ====
// self-checking bench for the termination controller
`timescale 1ns/10ps
`default_nettype none
module dot_ctrl_bench;
  logic              core_clk;
  logic              reset_n;
  logic              dq_drive;
  logic              banks_idle;
  logic              reg_wr;
  logic              reg_rd;
  logic [7:0]        reg_addr;
  logic [31:0]       reg_wdata;
  logic [31:0]       reg_rdata;
  logic              ck;
  logic              cke;
  logic              odt;
  dot_pkg::dot_cmd_s cmd;
  dot_pkg::dot_rtt_s rtt;
  int                fail_count = 0;
  int                checks = 0;
  int                cyc = 0;
  int                lat = 3;
  logic [31:0]       seed = 32'h0000_0007;
  bit                chk = 0;
  bit                odt_h[$];
  int                wr_h[$];
  logic              en_e = 1'h0;
  logic              dyn_e = 1'h0;
  logic              ce_in = 1'h1;
  logic [1:0]        bl_e = 2'h1;

  dot_mc_model mc (.ck(ck), .cke(cke), .odt(odt), .cmd(cmd));
  dot_ctrl #(.DEPTH(32)) uut (
    .core_clk(core_clk), .reset_n(reset_n), .ce(ce_in), .ck(ck), .cke(cke), .odt(odt),
    .cmd(cmd), .dq_drive(dq_drive), .banks_idle(banks_idle), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rtt(rtt));

  initial begin
    core_clk = 1'h0;
    forever #20 core_clk = ~core_clk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic logic [31:0] stat(input logic en, input logic dy, input logic [1:0] md,
                                       input logic tw, input int lt);
    return {20'h00000, 5'(lt), tw, md, dy, en, 2'h0};
  endfunction : stat

  task automatic final_report();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : final_report

  task automatic cmp_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : cmp_bit

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : cmp_word

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge core_clk);
    reg_wr <= 1'h0;
  endtask : reg_write

  // read data stand only in the cycle after the strobe
  task automatic reg_check(input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge core_clk);
    reg_rd <= 1'h0;
    #1;
    cmp_word(reg_rdata, e);
  endtask : reg_check

  // cl code 0 throughout (cl 4); cwl code chosen per call
  task automatic cfg(input int al, input logic [2:0] nm, input logic [1:0] wr,
                     input logic [2:0] cw);
    logic [15:0] m1;
    m1 = 16'h0000;
    m1[dot_pkg::MR1_AL_LO +: 2] = al[1:0];
    m1[dot_pkg::MR1_NOM2_BIT] = nm[2];
    m1[dot_pkg::MR1_NOM1_BIT] = nm[1];
    m1[dot_pkg::MR1_NOM0_BIT] = nm[0];
    reg_write(dot_pkg::MR1_OFS, {16'h0000, m1});
    reg_write(dot_pkg::MR2_OFS, {21'h000000, wr, 3'h0, cw, 3'h0});
    lat = 3 + cw + ((al == 1) ? 3 : (al == 2) ? 2 : 0);
    en_e = |{nm, wr};
    dyn_e = |wr;
    reg_check(dot_pkg::MR1_OFS, {16'h0000, m1});
    reg_check(dot_pkg::STAT_OFS, stat(en_e, dyn_e, 2'h0, 1'h0, lat));
    cmp_word({27'h0000000, rtt.nom_code, rtt.wr_code}, {27'h0000000, nm, wr});
  endtask : cfg

  // reference model: termination state at each link rise from pin history
  always @(posedge ck) begin : rise_model
    int   k;
    logic ue;
    k = odt_h.size();
    if (chk && k > lat + 8) begin
      ue = 1'h0;
      // a change lands half a clock after its latency edge, so it shows one rise later
      for (int d = lat + 1; d < lat + 8; d++)
        if (wr_h[k - d] != 0 && d < lat + 1 + wr_h[k - d]) ue = 1'h1;
      cmp_bit(rtt.on, en_e && odt_h[k - lat - 1]);
      cmp_bit(rtt.use_wr, dyn_e && ue);
    end
    odt_h.push_back(odt);
    wr_h.push_back((!cmd.cs_n && cmd.ras_n && !cmd.cas_n && !cmd.we_n) ?
                   ((bl_e == 2'h0 || (bl_e == 2'h1 && cmd.addr[dot_pkg::ADDR_BC_BIT]))
                    ? 6 : 4) : 0);
  end

  // hang guard, well above the length of the sequence
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fail_count++;
      final_report();
    end
  end

  initial begin : main
    logic [31:0] r;
    reset_n = 1'h0;
    dq_drive = 1'h0;
    banks_idle = 1'h0;
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    repeat (16) @(posedge core_clk);
    reset_n <= 1'h1;
    cmp_word({25'h0000000, rtt}, 32'h0000_0000);
    reg_write(8'h10, 32'hFFFF_FFFF);
    reg_write(dot_pkg::STAT_OFS, 32'hFFFF_FFFF);
    reg_check(8'h10, 32'h0000_0000);
    reg_check(dot_pkg::MR2_OFS, 32'h0000_0000);
    reg_check(dot_pkg::STAT_OFS, stat(1'h0, 1'h0, 2'h0, 1'h0, 3));
    // clock enable low: a register write must not land
    @(posedge core_clk);
    ce_in <= 1'h0;
    reg_write(dot_pkg::MR2_OFS, 32'h0000_FFFF);
    @(posedge core_clk);
    ce_in <= 1'h1;
    reg_check(dot_pkg::MR2_OFS, 32'h0000_0000);
    for (int c = 0; c < 4; c++) begin
      // burst length per pass: on the fly, fixed eight, then chop four
      bl_e = 2'(5 - c);
      reg_write(dot_pkg::MR0_OFS, {30'h00000000, bl_e});
      cfg(c % 3, (c == 3) ? 3'h0 : 3'(rnd() % 7 + 1), (c < 3) ? 2'(rnd() % 3 + 1) : 2'h0,
          3'(rnd() % 4));
      chk = 1;
      repeat (6) begin
        r = rnd();
        mc.burst(4 + r[1:0], r[2], r[3] | (bl_e == 2'h0));
        mc.rises(r[5:4]);
      end
      mc.rises(20);
      chk = 0;
    end
    // read: odt dropped before the data, raised again while the data is driven, bus released late
    cfg(0, 3'h1, 2'h0, 3'h0);
    mc.set_pin(1'h1, 1'h1);
    mc.rises(8);
    cmp_bit(rtt.on, 1'h1);
    mc.set_pin(1'h0, 1'h1);
    mc.rises(8);
    @(posedge core_clk);
    dq_drive <= 1'h1;
    repeat (3) @(posedge core_clk);
    cmp_bit(rtt.on, 1'h0);
    mc.set_pin(1'h1, 1'h1);
    mc.rises(8);
    cmp_bit(rtt.on, 1'h0);
    @(posedge core_clk);
    dq_drive <= 1'h0;
    repeat (3) @(posedge core_clk);
    cmp_bit(rtt.on, 1'h1);
    mc.set_pin(1'h0, 1'h1);
    mc.rises(20);
    banks_idle <= 1'h1;
    // frozen-dll bit set first (sync power-down), then clear (async)
    for (int fr = 1; fr >= 0; fr--) begin
      reg_write(dot_pkg::MR0_OFS, {19'h00000, fr[0], 12'h001});
      mc.set_pin(1'h0, 1'h0);
      mc.rises(1);
      repeat (5) @(posedge core_clk);
      reg_check(dot_pkg::STAT_OFS, stat(1'h1, 1'h0, fr ? 2'h1 : 2'h2, 1'h1, 3));
      mc.rises(6);
      reg_check(dot_pkg::STAT_OFS, stat(1'h1, 1'h0, fr ? 2'h1 : 2'h2, 1'h0, 3));
      if (fr == 0) begin
        mc.set_pin(1'h1, 1'h0);
        mc.rises(4);
        cmp_bit(rtt.on, 1'h1);
        mc.set_pin(1'h0, 1'h0);
        repeat (8) @(posedge core_clk);
        cmp_bit(rtt.on, 1'h0);
      end
      mc.set_pin(1'h0, 1'h1);
      mc.rises(10);
      reg_check(dot_pkg::STAT_OFS, stat(1'h1, 1'h0, 2'h0, 1'h0, 3));
    end
    // dll-off: write strength cleared by mode-set first, then no frozen-dll async mode
    reg_write(dot_pkg::MR2_OFS, 32'h0000_0600);
    mc.mrs(3'h2, 16'h0000);
    mc.mrs(3'h1, 16'h0005);
    mc.rises(2);
    reg_check(dot_pkg::MR2_OFS, 32'h0000_0000);
    reg_check(dot_pkg::MR1_OFS, 32'h0000_0005);
    mc.set_pin(1'h0, 1'h0);
    mc.rises(1);
    repeat (5) @(posedge core_clk);
    reg_check(dot_pkg::STAT_OFS, stat(1'h1, 1'h0, 2'h1, 1'h1, 3));
    mc.set_pin(1'h0, 1'h1);
    mc.rises(10);
    final_report();
  end
endmodule : dot_ctrl_bench
`default_nettype wire
